// >>> core/npd_burst_detect.sv
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`include "npd_defines.svh"
module npd_burst_detect #(
   parameter int HOLD_CYC = `NPD_HOLD_NS / `NPD_CLK_NS
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic link_clk_i,
   input wire logic link_sync_i,
   input wire logic link_lr_i,
   input wire logic link_data_i,
   input wire logic [4:0] bus_addr_i,
   input wire logic [7:0] bus_wdata_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   output logic [7:0] bus_rdata_o,
   output logic irq_o,
   output logic interrupt_out_0_o,
   output logic detect_o
);
   // ----------------------------------------
   // link front end
   // ----------------------------------------
   npd_pkg::npd_link_type link_raw;
   npd_pkg::npd_link_type link_s;
   npd_pkg::npd_word_type wd;
   npd_pkg::npd_core_state_type st, next_st;
   logic [2:0] ev;
   logic [7:0] info;

   assign link_raw = '{clk: link_clk_i, sync: link_sync_i, lr: link_lr_i, data: link_data_i};

   npd_sync u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .d_i(link_raw),
      .q_o(link_s)
   );

   npd_deser u_deser (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .link_i(link_s),
      .word_o(wd)
   );

   // ----------------------------------------
   // burst info decode
   // ----------------------------------------
   // type decode for software; bits 8-12 are left to software
   always_comb begin
      info = 8'h00;
      info[0] = st.pc_buf[4:0] == `NPD_TYPE_NULL;
      info[1] = st.pc_buf[4:0] == `NPD_TYPE_PAUSE;
      info[2] = st.pc_buf[4:0] == `NPD_TYPE_RES_A || st.pc_buf[4:0] == `NPD_TYPE_RES_B
         || st.pc_buf[4:0] >= `NPD_TYPE_RES_LOW;
      info[3] = st.pc_buf[`NPD_PC_ERR];
   end

   // ----------------------------------------
   // core next state
   // ----------------------------------------
   // one process for lock, parsing, timeout and registers
   always_comb begin
      next_st = st;
      ev = 3'h0;
      next_st.rdata = 8'h00;
      // time since the last subframe sync
      if (wd.sync) begin
         next_st.gap_cnt = 10'h000;
      end else if (st.gap_cnt != 10'(`NPD_GAP_CYC)) begin
         next_st.gap_cnt = 10'(st.gap_cnt + 10'h001);
      end
      // lock loss after between three and four missing syncs
      if (!wd.sync && st.gap_cnt == 10'(`NPD_GAP_CYC - 1)) begin
         next_st.relock_cnt = 3'h0;
         next_st.hold_cnt = 20'h00000;
         if (!st.unlocked) begin
            next_st.unlocked = 1'b1;
            ev[`NPD_IRQ_UNLOCK] = 1'b1;
         end
      end else if (st.unlocked) begin
         // relock after a few syncs, then hold the pin a while longer
         if (wd.sync && st.relock_cnt != `NPD_LOCK_SYNCS) begin
            next_st.relock_cnt = 3'(st.relock_cnt + 3'h1);
         end
         if (st.relock_cnt == `NPD_LOCK_SYNCS) begin
            if (st.hold_cnt == 20'(HOLD_CYC - 1)) begin
               next_st.unlocked = 1'b0;
            end else begin
               next_st.hold_cnt = 20'(st.hold_cnt + 20'h00001);
            end
         end
      end
      // frames since the last preamble, saturating just past the limit
      if (wd.valid && wd.left && st.frame_cnt <= `NPD_NOBURST_FRAMES) begin
         next_st.frame_cnt = 13'(st.frame_cnt + 13'h0001);
      end
      if (st.detect && st.frame_cnt > `NPD_NOBURST_FRAMES) begin
         next_st.detect = 1'b0;
         ev[`NPD_IRQ_LOST] = 1'b1;
      end
      // preamble search; a repeated sync a restarts the match
      if (wd.valid) begin
         case (st.burst)
            npd_pkg::NPD_HUNT: begin
               if (wd.data == `NPD_SYNC_A) begin
                  next_st.burst = npd_pkg::NPD_GOT_A;
               end
            end
            npd_pkg::NPD_GOT_A: begin
               if (wd.data == `NPD_SYNC_B) begin
                  next_st.burst = npd_pkg::NPD_GOT_B;
               end else if (wd.data != `NPD_SYNC_A) begin
                  next_st.burst = npd_pkg::NPD_HUNT;
               end
            end
            npd_pkg::NPD_GOT_B: begin
               next_st.pc_tmp = wd.data;
               next_st.burst = npd_pkg::NPD_GOT_C;
            end
            npd_pkg::NPD_GOT_C: begin
               // both buffers move in the same cycle, info held verbatim
               next_st.pc_buf = st.pc_tmp;
               next_st.pd_buf = wd.data;
               next_st.detect = 1'b1;
               next_st.frame_cnt = 13'h0000;
               next_st.burst = npd_pkg::NPD_HUNT;
               ev[`NPD_IRQ_BURST] = 1'b1;
            end
            default: begin
               next_st.burst = npd_pkg::NPD_HUNT;
            end
         endcase
      end
      // no stream, no detect: payload guesses would be stale
      if (next_st.unlocked) begin
         next_st.detect = 1'b0;
      end
      // register writes; write one to clear, an event in the same cycle wins
      if (bus_wr_i) begin
         case (bus_addr_i)
            `NPD_ADDR_IRQ_STAT: begin
               next_st.irq_stat = st.irq_stat & ~bus_wdata_i[2:0];
            end
            `NPD_ADDR_IRQ_MASK: begin
               next_st.irq_mask = bus_wdata_i[2:0];
            end
            `NPD_ADDR_CTRL: begin
               next_st.unlock_mask = bus_wdata_i[0];
            end
            default: begin
            end
         endcase
      end
      next_st.irq_stat = next_st.irq_stat | ev;
      // register reads; unmapped addresses answer zero
      if (bus_rd_i) begin
         case (bus_addr_i)
            `NPD_ADDR_STATUS: begin
               next_st.rdata[`NPD_STAT_DETECT] = st.detect;
               next_st.rdata[`NPD_STAT_UNLOCK] = st.unlocked;
            end
            `NPD_ADDR_PC0: next_st.rdata = st.pc_buf[7:0];
            `NPD_ADDR_PC1: next_st.rdata = st.pc_buf[15:8];
            `NPD_ADDR_PD0: next_st.rdata = st.pd_buf[7:0];
            `NPD_ADDR_PD1: next_st.rdata = st.pd_buf[15:8];
            `NPD_ADDR_INFO: next_st.rdata = info;
            `NPD_ADDR_IRQ_STAT: next_st.rdata = {5'h00, st.irq_stat};
            `NPD_ADDR_IRQ_MASK: next_st.rdata = {5'h00, st.irq_mask};
            `NPD_ADDR_CTRL: next_st.rdata = {7'h00, st.unlock_mask};
            default: next_st.rdata = 8'h00;
         endcase
      end
      // pin follows lock loss unless masked
      next_st.interrupt_out_0 = next_st.unlocked && !next_st.unlock_mask;
   end

   // ----------------------------------------
   // state register and outputs
   // ----------------------------------------
   // buffers clear at reset so software never reads junk
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign bus_rdata_o = st.rdata;
   assign irq_o = |(st.irq_stat & st.irq_mask);
   assign interrupt_out_0_o = st.interrupt_out_0;
   assign detect_o = st.detect;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_sync_a;
      ce_i && wd.valid && st.burst == npd_pkg::NPD_HUNT && wd.data == `NPD_SYNC_A
         |=> st.burst == npd_pkg::NPD_GOT_A;
   endproperty
   a_sync_a: assert property (p_sync_a) else $error("sync a not taken");

   property p_type_null;
      info[0] == (st.pc_buf[4:0] == `NPD_TYPE_NULL)
         && info[1] == (st.pc_buf[4:0] == `NPD_TYPE_PAUSE);
   endproperty
   a_type_null: assert property (p_type_null) else $error("type decode wrong");

   property p_err_flag;
      info[3] == st.pc_buf[`NPD_PC_ERR];
   endproperty
   a_err_flag: assert property (p_err_flag) else $error("error flag wrong");

   property p_detect_set;
      ce_i && wd.valid && st.burst == npd_pkg::NPD_GOT_C && !next_st.unlocked
         |=> st.detect && st.pd_buf == $past(wd.data) && st.frame_cnt == 13'h0000;
   endproperty
   a_detect_set: assert property (p_detect_set) else $error("burst not captured");

   property p_timeout;
      // a frozen enable holds the flag, so only a running cycle must drop it
      ce_i && st.frame_cnt > `NPD_NOBURST_FRAMES
         && !(wd.valid && st.burst == npd_pkg::NPD_GOT_C)
         |=> !st.detect;
   endproperty
   a_timeout: assert property (p_timeout) else $error("detect kept too long");

   property p_unlock;
      ce_i && !wd.sync && st.gap_cnt == 10'(`NPD_GAP_CYC - 1) && !st.unlock_mask
         && !(bus_wr_i && bus_addr_i == `NPD_ADDR_CTRL)
         |=> st.unlocked && interrupt_out_0_o && !st.detect;
   endproperty
   a_unlock: assert property (p_unlock) else $error("lock loss missed");

   property p_pin_level;
      interrupt_out_0_o == (st.unlocked && !st.unlock_mask);
   endproperty
   a_pin_level: assert property (p_pin_level) else $error("pin 0 level wrong");

   property p_read_pc;
      ce_i && bus_rd_i && bus_addr_i == `NPD_ADDR_PC0
         |=> bus_rdata_o == $past(st.pc_buf[7:0]);
   endproperty
   a_read_pc: assert property (p_read_pc) else $error("info byte read wrong");

   property p_read_status;
      ce_i && bus_rd_i && bus_addr_i == `NPD_ADDR_STATUS
         |=> bus_rdata_o[`NPD_STAT_DETECT] == $past(st.detect);
   endproperty
   a_read_status: assert property (p_read_status) else $error("status read wrong");

   property p_together;
      $changed(st.pc_buf) |-> $past(st.burst) == npd_pkg::NPD_GOT_C && $past(wd.valid);
   endproperty
   a_together: assert property (p_together) else $error("buffer moved alone");

   property p_set_wins;
      ce_i && ev[`NPD_IRQ_BURST] && bus_wr_i && bus_addr_i == `NPD_ADDR_IRQ_STAT
         && bus_wdata_i[`NPD_IRQ_BURST] |=> st.irq_stat[`NPD_IRQ_BURST];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

   c_burst: cover property (ce_i && ev[`NPD_IRQ_BURST]);
   c_lost: cover property (ce_i && ev[`NPD_IRQ_LOST]);
   c_unlock: cover property (ce_i && ev[`NPD_IRQ_UNLOCK]);
   c_relock: cover property ($fell(st.unlocked));
endmodule

// >>> core/npd_defines.svh
// Functional notes
// - preamble is sync a, sync b, info, length
// - info bits 0-4 give data type
// - info bit 7 flags payload error
// - info bits 8-12 kept, not interpreted
// - detect set on preamble, cleared after 4097 frames
// - lost syncs raise pin 0, drop detect
// - info and length readable at 0fh-12h
// - detect flag readable in status register
`ifndef NPD_DEFINES_SVH
`define NPD_DEFINES_SVH

// ----------------------------------------
// preamble words and info fields
// ----------------------------------------
`define NPD_SYNC_A 16'hf872
`define NPD_SYNC_B 16'h4e1f
`define NPD_WORD_LAST 5'h0f
`define NPD_PC_ERR 7
`define NPD_TYPE_NULL 5'h00
`define NPD_TYPE_RES_A 5'h02
`define NPD_TYPE_PAUSE 5'h03
`define NPD_TYPE_RES_B 5'h0a
`define NPD_TYPE_RES_LOW 5'h10

// ----------------------------------------
// register map and bits
// ----------------------------------------
`define NPD_ADDR_STATUS 5'h07
`define NPD_ADDR_PC0 5'h0f
`define NPD_ADDR_PC1 5'h10
`define NPD_ADDR_PD0 5'h11
`define NPD_ADDR_PD1 5'h12
`define NPD_ADDR_INFO 5'h1c
`define NPD_ADDR_IRQ_STAT 5'h1d
`define NPD_ADDR_IRQ_MASK 5'h1e
`define NPD_ADDR_CTRL 5'h1f
`define NPD_STAT_DETECT 6
`define NPD_STAT_UNLOCK 4
`define NPD_IRQ_BURST 0
`define NPD_IRQ_LOST 1
`define NPD_IRQ_UNLOCK 2

// ----------------------------------------
// timing
// ----------------------------------------
`define NPD_NOBURST_FRAMES 13'h1000
`define NPD_CLK_NS 40
`define NPD_SUBFRAME_NS 10240
`define NPD_GAP_CYC ((`NPD_SUBFRAME_NS * 7) / (2 * `NPD_CLK_NS))
`define NPD_LOCK_SYNCS 3'h4
`define NPD_HOLD_NS 1000000

`endif

// >>> core/npd_pkg.sv
`include "npd_defines.svh"
package npd_pkg;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {NPD_HUNT, NPD_GOT_A, NPD_GOT_B, NPD_GOT_C} npd_burst_type;

   typedef struct packed {
      logic clk;
      logic sync;
      logic lr;
      logic data;
   } npd_link_type;

   typedef struct packed {
      logic valid;
      logic sync;
      logic left;
      logic [15:0] data;
   } npd_word_type;

   typedef struct packed {
      npd_link_type s1;
      npd_link_type s2;
   } npd_sync_state_type;

   typedef struct packed {
      logic prev_clk;
      logic [4:0] bitcnt;
      logic [15:0] shift;
      logic left;
      npd_word_type word;
   } npd_deser_state_type;

   typedef struct packed {
      npd_burst_type burst;
      logic [15:0] pc_tmp;
      logic [15:0] pc_buf;
      logic [15:0] pd_buf;
      logic detect;
      logic [12:0] frame_cnt;
      logic [9:0] gap_cnt;
      logic unlocked;
      logic [2:0] relock_cnt;
      logic [19:0] hold_cnt;
      logic interrupt_out_0;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic unlock_mask;
      logic [7:0] rdata;
   } npd_core_state_type;

endpackage

// >>> core/npd_sync.sv
`timescale 1ns/1ps
module npd_sync (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire npd_pkg::npd_link_type d_i,
   output npd_pkg::npd_link_type q_o
);
   npd_pkg::npd_sync_state_type st, next_st;

   // two stages; only the second stage leaves this module
   always_comb begin
      next_st = st;
      next_st.s1 = d_i;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign q_o = st.s2;
endmodule

// >>> core/npd_deser.sv
`timescale 1ns/1ps
`include "npd_defines.svh"
module npd_deser (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire npd_pkg::npd_link_type link_i,
   output npd_pkg::npd_word_type word_o
);
   npd_pkg::npd_deser_state_type st, next_st;

   // shift msb first on each rising link clock; sync marks bit 0 of a subframe
   always_comb begin
      next_st = st;
      next_st.prev_clk = link_i.clk;
      next_st.word.valid = 1'b0;
      next_st.word.sync = 1'b0;
      if (link_i.clk && !st.prev_clk) begin
         if (link_i.sync) begin
            next_st.shift = {15'h0000, link_i.data};
            next_st.bitcnt = 5'h01;
            next_st.left = link_i.lr;
            next_st.word.sync = 1'b1;
         end else if (st.bitcnt != 5'h00 && st.bitcnt <= `NPD_WORD_LAST) begin
            next_st.shift = {st.shift[14:0], link_i.data};
            next_st.bitcnt = 5'(st.bitcnt + 5'h01);
            // bits past the word are ignored until the next sync
            if (st.bitcnt == `NPD_WORD_LAST) begin
               next_st.word.valid = 1'b1;
               next_st.word.data = {st.shift[14:0], link_i.data};
               next_st.word.left = st.left;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign word_o = st.word;
endmodule

// >>> dv/npd_tx_model.sv
`timescale 1ns/1ps
module npd_tx_model (
   output logic link_clk_o,
   output logic link_sync_o,
   output logic link_lr_o,
   output logic link_data_o
);
   // ----------------------------------------
   // word queue filled by the bench
   // ----------------------------------------
   logic [15:0] q[$];
   logic run = 1'b0;
   logic [15:0] w;
   int k;

   task automatic push(input logic [15:0] v);
      q.push_back(v);
   endtask

   // ----------------------------------------
   // subframe sender
   // ----------------------------------------
   // filler words keep the receiver locked between bursts; when stopped the
   // clock stands low and data toggles so no stale level looks like a bit
   initial begin
      link_clk_o = 1'b0;
      link_sync_o = 1'b0;
      link_lr_o = 1'b0;
      link_data_o = 1'b0;
      #7;
      forever begin
         if (!run) begin
            link_data_o = ~link_data_o;
            #320;
         end else begin
            w = (q.size() != 0) ? q.pop_front() : 16'h0000;
            link_lr_o = ~link_lr_o;
            for (k = 0; k < 32; k++) begin
               link_sync_o = (k == 0);
               link_data_o = (k < 16) ? w[15 - k] : ~link_data_o;
               #160 link_clk_o = 1'b1;
               #160 link_clk_o = 1'b0;
            end
         end
      end
   end
endmodule

// >>> dv/npd_burst_detect_bench.sv
`timescale 1ns/1ps
`include "npd_defines.svh"
module npd_burst_detect_bench;
   localparam int HOLD = 50;
   logic clk_i, rst_n_i, ce_i, bus_wr_i, bus_rd_i;
   logic [4:0] bus_addr_i;
   logic [7:0] bus_wdata_i;
   wire logic [7:0] bus_rdata_o;
   wire logic irq_o, interrupt_out_0_o, detect_o, lclk, lsync, llr, ldata;
   int fail_count = 0;
   int n_checks = 0;
   int n_cyc = 0;
   int t, i;
   logic [31:0] seed = 32'h00003583;
   logic [15:0] pc, pd;
   logic [7:0] s;

   npd_burst_detect #(.HOLD_CYC(HOLD)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .link_clk_i(lclk), .link_sync_i(lsync), .link_lr_i(llr), .link_data_i(ldata),
      .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i),
      .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o), .irq_o(irq_o),
      .interrupt_out_0_o(interrupt_out_0_o), .detect_o(detect_o));

   npd_tx_model tx (.link_clk_o(lclk), .link_sync_o(lsync), .link_lr_o(llr),
      .link_data_o(ldata));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] r;
      r = v ^ (v << 13);
      r = r ^ (r >> 17);
      return r ^ (r << 5);
   endfunction

   // info byte: null, pause, reserved type, payload error
   function automatic logic [7:0] exp_info(input logic [15:0] p);
      logic [4:0] ty;
      ty = p[4:0];
      return {4'h0, p[7], (ty == 5'h02 || ty == 5'h0a || ty >= 5'h10), ty == 5'h03, ty == 5'h00};
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // bus cycles, strobes one cycle, read data the cycle after
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus_addr_i <= a;
      bus_wdata_i <= d;
      bus_wr_i <= 1'b1;
      @(posedge clk_i);
      bus_wr_i <= 1'b0;
   endtask

   task automatic rdr(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk_i);
      bus_addr_i <= a;
      bus_rd_i <= 1'b1;
      @(posedge clk_i);
      bus_rd_i <= 1'b0;
      #1;
      d = bus_rdata_o;
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
      logic [7:0] d;
      rdr(a, d);
      check({8'h00, d}, {8'h00, e});
   endtask

   task automatic chk_buf(input logic [15:0] c, input logic [15:0] d);
      rd_chk(5'h0f, c[7:0]);
      rd_chk(5'h10, c[15:8]);
      rd_chk(5'h11, d[7:0]);
      rd_chk(5'h12, d[15:8]);
   endtask

   // polls the capture flag; bounded so a lost burst cannot hang
   task automatic wait_cap();
      s = 8'h00;
      for (i = 0; i < 900 && !s[0]; i++) rdr(5'h1d, s);
      check(16'(s[0]), 16'h0001);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------
   // clock and hang guard
   // ----------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      n_cyc++;
      if (n_cyc == 90000) begin
         fail_count++;
         $display("CHECK FAILED t=%0t timeout", $time);
         report_and_stop();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst_n_i = 1'b0;
      ce_i = 1'b1;
      bus_wr_i = 1'b0;
      bus_rd_i = 1'b0;
      bus_addr_i = 5'h00;
      bus_wdata_i = 8'h00;
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      tx.run = 1'b1;
      chk_buf(16'h0000, 16'h0000);
      rd_chk(5'h07, 8'h00);
      rd_chk(5'h03, 8'h00);
      wr(5'h0f, 8'hff);
      rd_chk(5'h0f, 8'h00);
      $display("test reset done");
      // broken pair of sync words must not capture
      tx.push(`NPD_SYNC_A);
      tx.push(16'h1234);
      tx.push(16'h0005);
      tx.push(16'h0100);
      while (tx.q.size() != 0) @(posedge clk_i);
      for (i = 0; i < 150; i++) rdr(5'h1d, s);
      check(16'(s[0]), 16'h0000);
      check(16'(detect_o), 16'h0000);
      $display("test broken preamble done");
      // every data type once, random error flag, info bits and length
      for (t = 0; t < 32; t++) begin
         seed = xs(seed);
         pc = {3'b000, seed[12:8], seed[7], 2'b00, t[4:0]};
         pd = seed[31:16];
         wr(5'h1e, (t == 0) ? 8'h00 : 8'h07);
         if (t[0]) tx.push(`NPD_SYNC_A);
         tx.push(`NPD_SYNC_A);
         tx.push(`NPD_SYNC_B);
         tx.push(pc);
         tx.push(pd);
         wait_cap();
         check(16'(irq_o), (t == 0) ? 16'h0000 : 16'h0001);
         chk_buf(pc, pd);
         rd_chk(5'h1c, exp_info(pc));
         rd_chk(5'h07, 8'h40);
         check(16'(detect_o), 16'h0001);
         wr(5'h1d, 8'h01);
         #1 check(16'(irq_o), 16'h0000);
      end
      $display("test data types done");
      // stream stops: pin rises, detect drops, buffers kept
      tx.run = 1'b0;
      for (i = 0; i < 1500 && !interrupt_out_0_o; i++) @(posedge clk_i);
      check(16'(interrupt_out_0_o), 16'h0001);
      check(16'(detect_o), 16'h0000);
      check(16'(irq_o), 16'h0001);
      rd_chk(5'h07, 8'h10);
      chk_buf(pc, pd);
      wr(5'h1f, 8'h01);
      repeat (2) @(posedge clk_i);
      check(16'(interrupt_out_0_o), 16'h0000);
      wr(5'h1f, 8'h00);
      tx.run = 1'b1;
      s = 8'h10;
      for (i = 0; i < 1500 && s[4]; i++) rdr(5'h07, s);
      check(16'(interrupt_out_0_o), 16'h0000);
      wr(5'h1d, 8'h07);
      $display("test unlock done");
      // detection resumes after relock
      tx.push(`NPD_SYNC_A);
      tx.push(`NPD_SYNC_B);
      tx.push(16'h1c05);
      tx.push(16'h2a40);
      wait_cap();
      chk_buf(16'h1c05, 16'h2a40);
      check(16'(detect_o), 16'h0001);
      $display("test relock done");
      // a frozen clock enable takes no write
      @(posedge clk_i);
      ce_i <= 1'b0;
      wr(5'h1e, 8'h00);
      ce_i <= 1'b1;
      rd_chk(5'h1e, 8'h07);
      $display("test clock enable done");
      report_and_stop();
   end
endmodule
